//--- sod_regs.svh
// register offsets, field positions, reset values and timing for the switch output block
// assumes a 25 MHz system clock and word-aligned AHB-Lite access
`ifndef SOD_REGS_SVH
`define SOD_REGS_SVH

// ********************
// register offsets
// ********************
`define SOD_AW           3
`define SOD_OFS_CTRL     3'h0
`define SOD_OFS_LOGIC    3'h1
`define SOD_OFS_DELAY    3'h2
`define SOD_OFS_SCN_LO   3'h3
`define SOD_OFS_SCN_HI   3'h4
`define SOD_OFS_SCN_STD  3'h5
`define SOD_OFS_STATUS   3'h6
`define SOD_OFS_COUNT    3'h7

// ********************
// field positions
// ********************
`define SOD_CT_RETRIG    0
`define SOD_CT_STDLOAD   1
`define SOD_CT_TDRCV     2
`define SOD_CT_TIMEEN    4
`define SOD_LC_ACT       0
`define SOD_LC_FN        1
`define SOD_LC_INV       3
`define SOD_LC_RCV       4
`define SOD_LC_BLK       6
`define SOD_LC_W         8
`define SOD_DL_OFF       16
`define SOD_SCN_W        8
`define SOD_ST_SCN       16

// ********************
// reset values and timing
// ********************
`define SOD_RST_ON_DLY   16'h0005
`define SOD_RST_OFF_DLY  16'h0005
`define SOD_RST_STDLOAD  1'b1
`define SOD_RST_TIMEEN   1'b1
`define SOD_CLK_NS       40
`define SOD_TICK_NS      1000000000

`endif

//--- sod_pkg.sv
// types shared by the switch output block
// assumes sod_regs.svh is on the include path
`include "sod_regs.svh"

package sod_pkg;

   // delay state, gray along idle-wait-idle
   typedef enum logic [1:0] {
      DLY_IDLE = 2'b00,
      DLY_ON   = 2'b01,
      DLY_OFF  = 2'b10
   } sod_dly_type;

   typedef enum logic [1:0] {
      FN_AND  = 2'b00,
      FN_OR   = 2'b01,
      FN_XOR  = 2'b10,
      FN_GATE = 2'b11
   } sod_func_type;

   // value loaded into an object on bus recovery
   typedef enum logic [1:0] {
      RCV_KEEP = 2'b00,
      RCV_ZERO = 2'b01,
      RCV_ONE  = 2'b10
   } sod_recov_type;

   typedef struct packed {
      logic                  p_sw;
      logic [1:0]            p_lc;
      logic                  p_td;
      logic                  p_sc;
      logic                  p_rs;
      logic                  p_ok;
      logic                  retrig;
      logic                  std_load;
      logic                  time_en;
      sod_recov_type         td_rcv;
      logic [1:0][7:0]       lcfg;
      logic [15:0]           on_dly;
      logic [15:0]           off_dly;
      logic [7:0][6:0]       scn_num;
      logic [7:0]            scn_std;
      logic [7:0]            scn_val;
      logic                  reload;
      logic                  sw_obj;
      logic                  tdis;
      logic [1:0]            lo;
      logic [1:0]            lo_ok;
      logic [1:0]            ghold;
      logic                  gate_off;
      logic                  cmd;
      logic                  contact;
      sod_dly_type           dly;
      logic [15:0]           cnt;
      logic [24:0]           pre;
      logic                  wr_pend;
      logic [2:0]            wr_addr;
      logic [31:0]           rdata;
      logic                  ready;
      logic                  resp;
   } sod_state_type;

endpackage

//--- sod_pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the pins change slowly against the system clock
`timescale 1ns/10ps
`default_nettype none

module sod_pin_sync #(
   parameter int W = 1
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          ce,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sod_sync_type;

   sod_sync_type r_reg;
   sod_sync_type r_next;

   // first stage feeds only the second
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         r_reg <= '0;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2;

endmodule

`default_nettype wire

//--- sod_switch_output.sv
// switched relay output: delays, time disable, scenes and two logic links
// assumes AHB-Lite single word transfers and telegram pins from the bus side
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sod_regs.svh"

module sod_switch_output #(
   parameter int TICK_CYCLES = `SOD_TICK_NS / `SOD_CLK_NS
) (
   input  wire logic         SYS_CLK,
   input  wire logic         NRST,
   input  wire logic         CE,
   input  wire logic         HSEL,
   input  wire logic [31:0]  HADDR,
   input  wire logic [1:0]   HTRANS,
   input  wire logic         HWRITE,
   input  wire logic [2:0]   HSIZE,
   input  wire logic [31:0]  HWDATA,
   input  wire logic         HREADY,
   output logic      [31:0]  HRDATA,
   output logic              HREADYOUT,
   output logic              HRESP,
   input  wire logic         SW_STB,
   input  wire logic         SW_VAL,
   input  wire logic         LC1_STB,
   input  wire logic         LC1_VAL,
   input  wire logic         LC2_STB,
   input  wire logic         LC2_VAL,
   input  wire logic         TDIS_STB,
   input  wire logic         TDIS_VAL,
   input  wire logic         SCN_STB,
   input  wire logic [7:0]   SCN_BYTE,
   input  wire logic         BUS_OK,
   input  wire logic         BUS_RST,
   output logic              CONTACT
);

   sod_pkg::sod_state_type r_reg;
   sod_pkg::sod_state_type r_next;

   logic        s_sw_stb;
   logic        s_sw_val;
   logic [1:0]  s_lc_stb;
   logic [1:0]  s_lc_val;
   logic        s_td_stb;
   logic        s_td_val;
   logic        s_sc_stb;
   logic [7:0]  s_sc_byte;
   logic        s_ok;
   logic        s_rs;
   logic [18:0] sync_q;

   // ********************
   // pin synchronisation
   // ********************
   sod_pin_sync #(.W(19)) u_sync (
      .clk  (SYS_CLK),
      .nrst (NRST),
      .ce   (CE),
      .d    ({SW_STB, SW_VAL, LC2_STB, LC1_STB, LC2_VAL, LC1_VAL, TDIS_STB, TDIS_VAL,
              SCN_STB, SCN_BYTE, BUS_OK, BUS_RST}),
      .q    (sync_q)
   );

   assign {s_sw_stb, s_sw_val, s_lc_stb, s_lc_val, s_td_stb, s_td_val,
           s_sc_stb, s_sc_byte, s_ok, s_rs} = sync_q;

   // ********************
   // next state
   // ********************
   always_comb begin
      logic                  tick;
      logic                  eval;
      logic                  sw_new;
      logic                  restart;
      logic                  recov;
      logic                  fail;
      logic                  v;
      logic                  res;
      logic                  blocked;
      logic                  timed;
      logic [6:0]            num;
      logic [2:0]            addr;
      logic [7:0]            cf;
      sod_pkg::sod_recov_type lr;
      tick    = 1'b0;
      eval    = 1'b0;
      sw_new  = 1'b0;
      restart = 1'b0;
      v       = 1'b0;
      res     = 1'b0;
      blocked = 1'b0;
      timed   = 1'b0;
      num     = 7'h00;
      cf      = 8'h00;
      lr      = sod_pkg::RCV_KEEP;
      addr    = HADDR[`SOD_AW+1:2];
      r_next  = r_reg;
      r_next.ready = 1'b1;
      r_next.resp  = 1'b0;
      recov   = s_ok & ~r_reg.p_ok;
      fail    = ~s_ok & r_reg.p_ok;
      r_next.p_sw = s_sw_stb;
      r_next.p_lc = s_lc_stb;
      r_next.p_td = s_td_stb;
      r_next.p_sc = s_sc_stb;
      r_next.p_rs = s_rs;
      r_next.p_ok = s_ok;

      // one-second timebase
      if (r_reg.pre == 25'(TICK_CYCLES - 1)) begin
         r_next.pre = 25'h0000000;
         tick       = 1'b1;
      end else begin
         r_next.pre = r_reg.pre + 25'h0000001;
      end

      // register write in the data phase
      if (r_reg.wr_pend) begin
         case (r_reg.wr_addr)
            `SOD_OFS_CTRL: begin
               r_next.retrig   = HWDATA[`SOD_CT_RETRIG];
               r_next.std_load = HWDATA[`SOD_CT_STDLOAD];
               r_next.td_rcv   = sod_pkg::sod_recov_type'(HWDATA[`SOD_CT_TDRCV +: 2]);
               r_next.time_en  = HWDATA[`SOD_CT_TIMEEN];
            end
            `SOD_OFS_LOGIC:  r_next.lcfg    = HWDATA[2*`SOD_LC_W-1:0];
            `SOD_OFS_DELAY: begin
               r_next.on_dly  = HWDATA[`SOD_DL_OFF-1:0];
               r_next.off_dly = HWDATA[`SOD_DL_OFF +: 16];
            end
            `SOD_OFS_SCN_LO: begin
               for (int j = 0; j < 4; j++) begin
                  r_next.scn_num[j] = HWDATA[j*`SOD_SCN_W +: 7];
               end
            end
            `SOD_OFS_SCN_HI: begin
               for (int j = 0; j < 4; j++) begin
                  r_next.scn_num[j+4] = HWDATA[j*`SOD_SCN_W +: 7];
               end
            end
            `SOD_OFS_SCN_STD: r_next.scn_std = HWDATA[7:0];
            default: ;
         endcase
      end

      // reload of standard scene values after reset
      if (r_reg.reload) begin
         r_next.reload = 1'b0;
         if (r_reg.std_load) begin
            r_next.scn_val = r_reg.scn_std;
         end
      end

      // delay countdown
      if (tick && r_reg.dly != sod_pkg::DLY_IDLE) begin
         if (r_reg.cnt <= 16'h0001) begin
            r_next.contact = (r_reg.dly == sod_pkg::DLY_ON);
            r_next.dly     = sod_pkg::DLY_IDLE;
         end else begin
            r_next.cnt = r_reg.cnt - 16'h0001;
         end
      end

      // telegrams, taken only while the bus is up
      if (s_ok) begin
         if (s_rs && !r_reg.p_rs) begin
            r_next.dly    = sod_pkg::DLY_IDLE;
            r_next.reload = 1'b1;
         end
         if (s_td_stb && !r_reg.p_td) begin
            r_next.tdis = s_td_val;
         end
         for (int c = 0; c < 2; c++) begin
            if (s_lc_stb[c] && !r_reg.p_lc[c]) begin
               r_next.lo[c]    = s_lc_val[c];
               r_next.lo_ok[c] = 1'b1;
               r_next.gate_off = 1'b0;
               eval            = 1'b1;
            end
         end
         if (s_sw_stb && !r_reg.p_sw) begin
            r_next.sw_obj = s_sw_val;
            eval          = 1'b1;
            sw_new        = 1'b1;
         end
         if (s_sc_stb && !r_reg.p_sc) begin
            num = {1'b0, s_sc_byte[5:0]} + 7'h01;
            for (int j = 0; j < 8; j++) begin
               if (r_reg.scn_num[j] == num) begin
                  if (s_sc_byte[7]) begin
                     r_next.scn_val[j] = r_reg.contact;
                  end else begin
                     r_next.sw_obj = r_reg.scn_val[j];
                     eval          = 1'b1;
                     sw_new        = 1'b1;
                     restart       = 1'b1;
                  end
               end
            end
         end
      end

      // bus voltage recovery
      if (recov) begin
         r_next.sw_obj = 1'b0;
         if (r_reg.td_rcv != sod_pkg::RCV_KEEP) begin
            r_next.tdis = (r_reg.td_rcv == sod_pkg::RCV_ONE);
         end
         for (int c = 0; c < 2; c++) begin
            lr = sod_pkg::sod_recov_type'(r_reg.lcfg[c][`SOD_LC_RCV +: 2]);
            if (lr != sod_pkg::RCV_KEEP) begin
               r_next.lo[c]    = (lr == sod_pkg::RCV_ONE);
               r_next.lo_ok[c] = 1'b1;
               eval            = 1'b1;
            end
         end
      end

      // bus voltage failure: values kept, gate and delays stop
      if (fail) begin
         r_next.gate_off = 1'b1;
         r_next.dly      = sod_pkg::DLY_IDLE;
      end

      // logic chain, link 1 first then link 2
      v = r_next.sw_obj;
      for (int c = 0; c < 2; c++) begin
         cf = r_reg.lcfg[c];
         if (cf[`SOD_LC_ACT] && r_next.lo_ok[c]) begin
            blocked = (r_next.lo[c] == cf[`SOD_LC_BLK]) && !r_next.gate_off;
            case (sod_pkg::sod_func_type'(cf[`SOD_LC_FN +: 2]))
               sod_pkg::FN_AND: res = v & r_next.lo[c];
               sod_pkg::FN_OR:  res = v | r_next.lo[c];
               sod_pkg::FN_XOR: res = v ^ r_next.lo[c];
               sod_pkg::FN_GATE: begin
                  if (r_next.gate_off) begin
                     res = v;
                  end else begin
                     if (sw_new && !blocked) begin
                        r_next.ghold[c] = v;
                     end
                     res = r_next.ghold[c];
                  end
               end
               default: res = v;
            endcase
            v = res ^ cf[`SOD_LC_INV];
         end
      end

      // delay control on each evaluation
      if (eval) begin
         r_next.cmd = v;
         timed      = r_reg.time_en && !r_next.tdis;
         if (!timed) begin
            r_next.contact = v;
            r_next.dly     = sod_pkg::DLY_IDLE;
         end else if (v == r_next.contact && !restart) begin
            r_next.dly = sod_pkg::DLY_IDLE;
         end else if (v) begin
            if (r_next.dly == sod_pkg::DLY_ON && !r_reg.retrig && !restart) begin
               r_next.dly = sod_pkg::DLY_ON;
            end else if (r_reg.on_dly == 16'h0000) begin
               r_next.contact = 1'b1;
               r_next.dly     = sod_pkg::DLY_IDLE;
            end else begin
               r_next.dly = sod_pkg::DLY_ON;
               r_next.cnt = r_reg.on_dly;
            end
         end else begin
            if (r_next.dly == sod_pkg::DLY_OFF && !r_reg.retrig && !restart) begin
               r_next.dly = sod_pkg::DLY_OFF;
            end else if (r_reg.off_dly == 16'h0000) begin
               r_next.contact = 1'b0;
               r_next.dly     = sod_pkg::DLY_IDLE;
            end else begin
               r_next.dly = sod_pkg::DLY_OFF;
               r_next.cnt = r_reg.off_dly;
            end
         end
      end

      // address phase: decode, then read data from the updated state
      r_next.wr_pend = 1'b0;
      if (HSEL && HTRANS[1] && HREADY) begin
         r_next.wr_pend = HWRITE;
         r_next.wr_addr = addr;
         r_next.rdata   = 32'h00000000;
         if (!HWRITE) begin
            case (addr)
               `SOD_OFS_CTRL: begin
                  r_next.rdata[`SOD_CT_RETRIG]      = r_next.retrig;
                  r_next.rdata[`SOD_CT_STDLOAD]     = r_next.std_load;
                  r_next.rdata[`SOD_CT_TDRCV +: 2]  = r_next.td_rcv;
                  r_next.rdata[`SOD_CT_TIMEEN]      = r_next.time_en;
               end
               `SOD_OFS_LOGIC:  r_next.rdata[2*`SOD_LC_W-1:0] = r_next.lcfg;
               `SOD_OFS_DELAY:  r_next.rdata = {r_next.off_dly, r_next.on_dly};
               `SOD_OFS_SCN_LO: begin
                  for (int j = 0; j < 4; j++) begin
                     r_next.rdata[j*`SOD_SCN_W +: 7] = r_next.scn_num[j];
                  end
               end
               `SOD_OFS_SCN_HI: begin
                  for (int j = 0; j < 4; j++) begin
                     r_next.rdata[j*`SOD_SCN_W +: 7] = r_next.scn_num[j+4];
                  end
               end
               `SOD_OFS_SCN_STD: r_next.rdata[7:0] = r_next.scn_std;
               `SOD_OFS_STATUS: begin
                  r_next.rdata[12:0] = {r_next.dly, r_next.gate_off, r_next.ghold,
                                        r_next.lo_ok, r_next.lo, r_next.sw_obj,
                                        r_next.tdis, r_next.cmd, r_next.contact};
                  r_next.rdata[`SOD_ST_SCN +: 8] = r_next.scn_val;
               end
               `SOD_OFS_COUNT:  r_next.rdata[15:0] = r_next.cnt;
               default:         r_next.rdata = 32'h00000000;
            endcase
         end
      end
   end

   // ********************
   // state register
   // ********************
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         r_reg          <= '0;
         r_reg.on_dly   <= `SOD_RST_ON_DLY;
         r_reg.off_dly  <= `SOD_RST_OFF_DLY;
         r_reg.std_load <= `SOD_RST_STDLOAD;
         r_reg.time_en  <= `SOD_RST_TIMEEN;
         r_reg.reload   <= 1'b1;
         r_reg.ready    <= 1'b1;
      end else if (CE) begin
         r_reg <= r_next;
      end
   end

   assign HRDATA    = r_reg.rdata;
   assign HREADYOUT = r_reg.ready;
   assign HRESP     = r_reg.resp;
   assign CONTACT   = r_reg.contact;

endmodule

`default_nettype wire

//--- sod_bus_model.sv
// bus side model: delivers switch, logic, time-disable and scene telegrams
// assumes send is entered just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none

module sod_bus_model (
   input  wire logic        clk,
   output logic      [4:0]  stb,
   output logic      [3:0]  val,
   output logic      [7:0]  scn
);
   // ****************
   // telegram timing
   // ****************
   // idle lines at time zero
   initial begin
      stb = 5'h00;
      val = 4'h0;
      scn = 8'h00;
   end

   // data set up 3 cycles, strobe 3 high, 3 low, then data no longer held
   task automatic send(input int k, input logic [7:0] d);
      val <= {4{d[0]}};
      scn <= d;
      repeat (3) @(posedge clk);
      stb[k] <= 1'b1;
      repeat (3) @(posedge clk);
      stb[k] <= 1'b0;
      repeat (3) @(posedge clk);
      val <= {4{~d[0]}}; // hold time over: show the inverse
      scn <= ~d;
      @(posedge clk);
   endtask
endmodule

`default_nettype wire

//--- sod_switch_output_sva.sv
// checker for the switch output block: contact timing and bus answers
// assumes a bind to sod_switch_output; it sees only that module's ports
`timescale 1ns/10ps
`default_nettype none

module sod_switch_output_chk #(
   parameter int TICK_CYCLES = 20
) (
   input  wire logic         SYS_CLK,
   input  wire logic         NRST,
   input  wire logic         CE,
   input  wire logic         HSEL,
   input  wire logic [31:0]  HADDR,
   input  wire logic [1:0]   HTRANS,
   input  wire logic         HWRITE,
   input  wire logic [31:0]  HWDATA,
   input  wire logic         HREADY,
   input  wire logic [31:0]  HRDATA,
   input  wire logic         HREADYOUT,
   input  wire logic         HRESP,
   input  wire logic         SW_STB,
   input  wire logic         SW_VAL,
   input  wire logic         LC1_STB,
   input  wire logic         LC2_STB,
   input  wire logic         TDIS_STB,
   input  wire logic         TDIS_VAL,
   input  wire logic         SCN_STB,
   input  wire logic         BUS_OK,
   input  wire logic         BUS_RST,
   input  wire logic         CONTACT
);
   logic         wr_ph;
   logic [2:0]   wr_a;
   logic [31:0]  ctrl_q;
   logic [31:0]  lg_q;
   logic [31:0]  dly_q;
   logic         tdis;
   logic         sw_v;
   logic         timed;
   int           wait_c;
   int           on_s;
   int           of_s;

   // ****************
   // shadow state
   // ****************
   assign timed = ctrl_q[4] && !tdis;
   assign on_s  = int'(dly_q[15:0]);
   assign of_s  = int'(dly_q[31:16]);

   // snoop writes, time-disable object and cycles since the last cause
   always_ff @(posedge SYS_CLK) begin
      wr_ph <= NRST && CE && HSEL && HTRANS[1] && HWRITE && HREADY;
      wr_a <= HADDR[4:2];
      if ($rose(SW_STB)) begin
         sw_v <= SW_VAL;
      end
      if (!NRST || wr_ph || $changed(BUS_OK) || $rose(BUS_RST) || $rose(SW_STB)
          || $rose(SCN_STB) || $rose(LC1_STB) || $rose(LC2_STB) || $rose(TDIS_STB)) begin
         wait_c <= 0;
      end else if (CE) begin
         wait_c <= wait_c + 1;
      end
      if (!NRST) begin
         ctrl_q <= 32'h0000_0012;
         lg_q <= 32'h0000_0000;
         dly_q <= 32'h0005_0005;
         tdis <= 1'b0;
      end else begin
         ctrl_q <= (wr_ph && wr_a == 3'h0) ? HWDATA : ctrl_q;
         lg_q <= (wr_ph && wr_a == 3'h1) ? HWDATA : lg_q;
         dly_q <= (wr_ph && wr_a == 3'h2) ? HWDATA : dly_q;
         if ($rose(TDIS_STB) && BUS_OK) begin
            tdis <= TDIS_VAL;
         end else if ($rose(BUS_OK) && ctrl_q[3:2] != 2'h0) begin
            tdis <= (ctrl_q[3:2] == 2'h2);
         end
      end
   end

   // ****************
   // assertions
   // ****************
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   bus_ready_a: assert property (HREADYOUT)
      else $error("bus slave inserted a wait state");
   resp_okay_a: assert property (!HRESP)
      else $error("bus slave answered with an error");
   rst_open_a: assert property ($rose(NRST) |-> !CONTACT)
      else $error("contact not open after reset");
   ce_hold_a: assert property (!CE |=> $stable(CONTACT) && $stable(HRDATA))
      else $error("state moved while clock enable low");
   direct_sw_a: assert property (!timed && lg_q == 32'h0 && BUS_OK && $rose(SW_STB)
      |-> ##[3:5] (CONTACT == sw_v)) else $error("untimed switch not followed");
   quiet_hold_a: assert property (!timed && $changed(CONTACT) |-> wait_c <= 6)
      else $error("untimed contact moved without a cause");
   on_time_a: assert property (timed && ctrl_q[0] && $rose(CONTACT) |->
      wait_c >= (on_s - 1) * TICK_CYCLES && wait_c <= on_s * TICK_CYCLES + 8)
      else $error("switch-on delay out of range");
   off_time_a: assert property (timed && ctrl_q[0] && $fell(CONTACT) |->
      wait_c >= (of_s - 1) * TICK_CYCLES && wait_c <= of_s * TICK_CYCLES + 8)
      else $error("switch-off delay out of range");
endmodule

bind sod_switch_output sod_switch_output_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
   .SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SW_STB(SW_STB),
   .SW_VAL(SW_VAL), .LC1_STB(LC1_STB), .LC2_STB(LC2_STB), .TDIS_STB(TDIS_STB),
   .TDIS_VAL(TDIS_VAL), .SCN_STB(SCN_STB), .BUS_OK(BUS_OK), .BUS_RST(BUS_RST),
   .CONTACT(CONTACT));

`default_nettype wire

//--- sod_tb.sv
// testbench for the switch output block: delays, scenes and logic links
// assumes sod_bus_model for telegrams and the bound checker beside the block
`timescale 1ns/10ps
`default_nettype none

module tb;
   localparam int T = 20;
   logic         SYS_CLK;
   logic         NRST;
   logic         CE;
   logic         HSEL;
   logic [31:0]  HADDR;
   logic [1:0]   HTRANS;
   logic         HWRITE;
   logic [31:0]  HWDATA;
   logic [31:0]  HRDATA;
   logic         HREADYOUT;
   logic         HRESP;
   logic [4:0]   stb;
   logic [3:0]   val;
   logic [7:0]   scn;
   logic         BUS_OK;
   logic         BUS_RST;
   logic         CONTACT;
   logic [31:0]  rd;
   int           n_mismatch;
   int           n_checks;

   // ****************
   // block, bus side and clock
   // ****************
   sod_switch_output #(.TICK_CYCLES(T)) sod_switch_output_i (
      .SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
      .SW_STB(stb[0]), .SW_VAL(val[0]), .LC1_STB(stb[1]), .LC1_VAL(val[1]),
      .LC2_STB(stb[2]), .LC2_VAL(val[2]), .TDIS_STB(stb[3]), .TDIS_VAL(val[3]),
      .SCN_STB(stb[4]), .SCN_BYTE(scn), .BUS_OK(BUS_OK), .BUS_RST(BUS_RST),
      .CONTACT(CONTACT));
   sod_bus_model sod_bus_model_i (.clk(SYS_CLK), .stb(stb), .val(val), .scn(scn));

   // free-running 25 MHz clock
   initial SYS_CLK = 1'b0;
   always #20 SYS_CLK = ~SYS_CLK;

   // ****************
   // shared tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic con(input logic e);
      chk({31'h0, CONTACT}, {31'h0, e});
   endtask

   // single word transfer, address phase then data phase
   task automatic ahb(input logic w, input logic [2:0] idx, input logic [31:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {27'h0, idx, 2'h0};
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= wd;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask

   task automatic send(input int k, input logic [7:0] d);
      sod_bus_model_i.send(k, d);
   endtask

   task automatic wait_con(input logic e, input int lim);
      int i;
      for (i = 0; i < lim && CONTACT !== e; i++) begin
         @(posedge SYS_CLK);
      end
      con(e);
   endtask

   task automatic bus_cycle();
      BUS_OK <= 1'b0;
      repeat (8) @(posedge SYS_CLK);
      BUS_OK <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_regs();
      ahb(1'b0, 3'h0, 32'h0);
      chk(rd, 32'h0000_0012);
      ahb(1'b0, 3'h2, 32'h0);
      chk(rd, 32'h0005_0005);
      ahb(1'b1, 3'h7, 32'h0000_FFFF);
      ahb(1'b1, 3'h2, 32'h0001_0003);
      ahb(1'b0, 3'h7, 32'h0);
      chk(rd, 32'h0000_0000);
      ahb(1'b0, 3'h2, 32'h0);
      chk(rd, 32'h0001_0003);
   endtask

   task automatic t_recov();
      ahb(1'b1, 3'h0, 32'h0000_001A);
      bus_cycle();
      send(0, 8'h01);
      con(1'b1);
      send(0, 8'h00);
      ahb(1'b1, 3'h0, 32'h0000_0016);
      bus_cycle();
      send(0, 8'h01);
      con(1'b0);
      wait_con(1'b1, 4 * T);
      send(0, 8'h00);
      wait_con(1'b0, 2 * T);
      send(3, 8'h01);
      send(0, 8'h01);
      con(1'b1);
      send(0, 8'h00);
      send(3, 8'h00);
   endtask

   task automatic t_retrig();
      int r;
      for (r = 0; r < 2; r++) begin
         ahb(1'b1, 3'h0, {31'h0000_0009, r[0]});
         send(0, 8'h01);
         repeat (30) @(posedge SYS_CLK);
         send(0, 8'h01);
         repeat (25) @(posedge SYS_CLK);
         con(r == 0);
         wait_con(1'b1, 3 * T);
         send(0, 8'h00);
         wait_con(1'b0, 2 * T);
      end
   endtask

   // slot 0 holds scene 24 (standard on), slot 1 scene 1 (standard off)
   task automatic t_scene();
      ahb(1'b1, 3'h0, 32'h0000_0002);
      ahb(1'b1, 3'h3, 32'h0000_0118);
      ahb(1'b1, 3'h5, 32'h0000_0001);
      BUS_RST <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      BUS_RST <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      send(4, 8'h17);
      con(1'b1);
      send(4, 8'h00);
      con(1'b0);
      send(0, 8'h01);
      send(4, 8'h80);
      send(0, 8'h00);
      send(4, 8'h00);
      con(1'b1);
      send(4, 8'h3F);
      con(1'b1);
      BUS_RST <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      BUS_RST <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      send(4, 8'h00);
      con(1'b0);
   endtask

   task automatic t_logic();
      int k;
      int i;
      logic a;
      logic b;
      for (k = 0; k < 4; k++) begin
         ahb(1'b1, 3'h1, (k == 3) ? 32'h0000_000D : {29'h0, k[1:0], 1'b1});
         for (i = 0; i < 4; i++) begin
            a = i[1];
            b = i[0];
            send(1, {7'h0, a});
            send(0, {7'h0, b});
            con(k == 0 ? a & b : k == 1 ? a | b : k == 2 ? a ^ b : ~(a ^ b));
         end
      end
      ahb(1'b1, 3'h1, 32'h0000_0103);
      send(0, 8'h00);
      con(1'b1);
      send(2, 8'h00);
      con(1'b0);
      send(2, 8'h01);
      con(1'b1);
      ahb(1'b1, 3'h1, 32'h0000_1047);
      send(1, 8'h00);
      send(0, 8'h01);
      send(1, 8'h01);
      send(0, 8'h00);
      con(1'b1);
      send(1, 8'h00);
      con(1'b1);
      send(0, 8'h00);
      con(1'b0);
      send(1, 8'h01);
      BUS_OK <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      send(0, 8'h01);
      con(1'b0);
      BUS_OK <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      send(0, 8'h01);
      con(1'b1);
      ahb(1'b0, 3'h6, 32'h0);
      chk({29'h0, rd[10], rd[5:4]}, 32'h0000_0005);
      CE <= 1'b0;
      repeat (10) @(posedge SYS_CLK);
      CE <= 1'b1;
      con(1'b1);
   endtask

   // ****************
   // run control
   // ****************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // reset, then the scenarios in turn
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      NRST = 1'b0;
      CE = 1'b1;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HWDATA = 32'h0;
      BUS_OK = 1'b1;
      BUS_RST = 1'b0;
      repeat (6) @(posedge SYS_CLK);
      NRST <= 1'b1;
      @(posedge SYS_CLK);
      t_regs();
      t_recov();
      t_retrig();
      t_scene();
      t_logic();
      tally_and_finish();
   end

   // cuts a hang short well past the expected run length
   initial begin
      #(20000 * 40);
      n_mismatch++;
      $display("FAIL %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule

`default_nettype wire
